//--- dv/hpm_host.sv
`default_nettype none
module hpm_host (
   input wire logic REF_CLK,
   input wire logic [15:0] HOST_DATA_LINES_OUT,
   output logic HOST_CHIP_SEL_N,
   output logic HOST_READ_STROBE_N,
   output logic HOST_WRITE_STROBE_N,
   output logic HOST_DATA_CMD_SEL,
   output logic HOST_ADDR_LATCH_EN,
   output logic [15:0] HOST_DATA_LINES_IN
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] q;
   initial {HOST_CHIP_SEL_N, HOST_READ_STROBE_N, HOST_WRITE_STROBE_N} = 3'h7;
   initial {HOST_DATA_CMD_SEL, HOST_ADDR_LATCH_EN, HOST_DATA_LINES_IN} = '0;
   task automatic cyc(input logic rd, input logic dc, input logic [15:0] d);
      @(posedge REF_CLK);
      HOST_CHIP_SEL_N <= 1'b0;
      HOST_DATA_CMD_SEL <= dc;
      HOST_DATA_LINES_IN <= d;
      HOST_READ_STROBE_N <= !rd;
      HOST_WRITE_STROBE_N <= rd;
      @(posedge REF_CLK);
      @(negedge REF_CLK);
      q = HOST_DATA_LINES_OUT;
      @(posedge REF_CLK);
      {HOST_READ_STROBE_N, HOST_WRITE_STROBE_N} <= 2'h3;
      @(posedge REF_CLK);
      HOST_CHIP_SEL_N <= 1'b1;
      // Released lines float, so show a changed pattern
      HOST_DATA_LINES_IN <= ~d;
   endtask
   task automatic ale(input logic [7:0] a);
      @(posedge REF_CLK);
      HOST_CHIP_SEL_N <= 1'b0;
      HOST_ADDR_LATCH_EN <= 1'b1;
      HOST_DATA_LINES_IN <= {8'h5a, a};
      @(posedge REF_CLK);
      HOST_CHIP_SEL_N <= 1'b1;
      HOST_ADDR_LATCH_EN <= 1'b0;
      HOST_DATA_LINES_IN <= {8'ha5, ~a};
   endtask
endmodule
`default_nettype wire

//--- dv/hpm_pin_mux_chk.sv
`default_nettype none
module hpm_pin_mux_chk (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic [2:0] CONFIG_STRAPS,
   input wire logic HOST_CHIP_SEL_N,
   input wire logic HOST_READ_STROBE_N,
   input wire logic [7:0] PIX_GREEN,
   input wire logic [7:0] PIX_BLUE,
   input wire logic PIX_VSYNC,
   input wire logic PIX_HSYNC,
   input wire logic PIX_DE,
   input wire logic [7:0] PANEL_GREEN_LINE,
   input wire logic [7:0] PANEL_BLUE_LINE,
   input wire logic PANEL_VSYNC,
   input wire logic PANEL_HSYNC,
   input wire logic PANEL_DATA_ENABLE,
   input wire logic HOST_DATA_OE_LOW,
   input wire logic HOST_DATA_OE_HIGH,
   input wire logic MEM_WRITE,
   input wire logic MEM_READ,
   input wire logic [1:0] MEM_WBYTES,
   input wire logic [7:0] PIX_RED,
   input wire logic TEAR_OR_IRQ_SRC,
   input wire logic TEAR_OR_IRQ_OUT,
   input wire logic [7:0] PANEL_RED_LINE,
   input wire logic BUS_IS_8BIT,
   input wire logic BUS_IS_ALE,
   input wire logic STRAP_RESERVED,
   input wire logic COLOUR_24BPP
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);
   property p_w;
      $past(RST) |-> BUS_IS_8BIT == $past(CONFIG_STRAPS[0]);
   endproperty
   a_w: assert property (p_w) else $error("width decode");
   property p_t;
      $past(RST) |-> {STRAP_RESERVED, BUS_IS_ALE} ==
         {$past(CONFIG_STRAPS[2]), $past(CONFIG_STRAPS[2:1]) == 2'h1};
   endproperty
   a_t: assert property (p_t) else $error("type decode");
   property p_h;
      !$past(RST) |-> $stable({BUS_IS_8BIT, BUS_IS_ALE, STRAP_RESERVED});
   endproperty
   a_h: assert property (p_h) else $error("decode moved");
   property p_r;
      STRAP_RESERVED |-> !(HOST_DATA_OE_LOW || MEM_WRITE || MEM_READ);
   endproperty
   a_r: assert property (p_r) else $error("reserved active");
   property p_u;
      HOST_DATA_OE_HIGH |-> !BUS_IS_8BIT && HOST_DATA_OE_LOW;
   endproperty
   a_u: assert property (p_u) else $error("upper driven");
   property p_b;
      MEM_WRITE && BUS_IS_8BIT |-> MEM_WBYTES inside {2'h1, 2'h2};
   endproperty
   a_b: assert property (p_b) else $error("wide write");
   property p_l;
      !$past(RST) |-> PANEL_RED_LINE[7:2] == $past(PIX_RED[7:2]) &&
         (!$past(COLOUR_24BPP) || PANEL_RED_LINE[1:0] == $past(PIX_RED[1:0]));
   endproperty
   a_l: assert property (p_l) else $error("lane map");
   property p_s;
      !$past(RST) |-> TEAR_OR_IRQ_OUT == $past(TEAR_OR_IRQ_SRC);
   endproperty
   a_s: assert property (p_s) else $error("tear path");
   property p_y;
      !$past(RST) |-> {PANEL_VSYNC, PANEL_HSYNC, PANEL_DATA_ENABLE} ==
         $past({PIX_VSYNC, PIX_HSYNC, PIX_DE}) &&
         PANEL_GREEN_LINE[7:2] == $past(PIX_GREEN[7:2]) &&
         PANEL_BLUE_LINE[7:2] == $past(PIX_BLUE[7:2]) &&
         (!$past(COLOUR_24BPP) || {PANEL_GREEN_LINE[1:0],
         PANEL_BLUE_LINE[1:0]} == $past({PIX_GREEN[1:0], PIX_BLUE[1:0]}));
   endproperty
   a_y: assert property (p_y) else $error("panel path");
   property p_o;
      !$past(RST) |-> HOST_DATA_OE_LOW == (!STRAP_RESERVED &&
         $past(!HOST_CHIP_SEL_N && !HOST_READ_STROBE_N));
   endproperty
   a_o: assert property (p_o) else $error("read enable");
endmodule
bind hpm_pin_mux hpm_pin_mux_chk i_hpm_pin_mux_chk (.*);
`default_nettype wire

//--- dv/hpm_pin_mux_tb_top.sv
`default_nettype none
module hpm_pin_mux_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import hpm_pkg::*;
   logic REF_CLK = 0, RST = 1, TEAR_OR_IRQ_SRC = 0, PIX_VSYNC = 0;
   logic PIX_HSYNC = 0, PIX_DE = 0, HOST_DATA_OE_LOW, HOST_DATA_OE_HIGH;
   logic [2:0] CONFIG_STRAPS = 0;
   logic [15:0] MEM_RDATA = 0, HOST_DATA_LINES_OUT, MEM_WDATA, wd, d;
   logic [15:0] HOST_DATA_LINES_IN;
   logic [7:0] PIX_RED = 0, PIX_GREEN = 0, PIX_BLUE = 0;
   logic [7:0] PANEL_RED_LINE, PANEL_GREEN_LINE, PANEL_BLUE_LINE;
   logic [3:0] GENERAL_OUTPUT;
   logic [1:0] MEM_WBYTES, wb;
   logic HOST_CHIP_SEL_N, HOST_READ_STROBE_N, HOST_WRITE_STROBE_N;
   logic HOST_DATA_CMD_SEL, HOST_ADDR_LATCH_EN, TEAR_OR_IRQ_OUT;
   logic MEM_WRITE, MEM_READ, PANEL_VSYNC, PANEL_HSYNC, PANEL_DATA_ENABLE;
   logic BUS_IS_8BIT, BUS_IS_ALE, STRAP_RESERVED, COLOUR_24BPP;
   int error_cnt = 0, tests_run = 0, wn = 0, rn = 0, n, seed = 92086;
   hpm_pin_mux i_hpm_pin_mux (.*);
   hpm_host i_hpm_host (.*);
   always #5 REF_CLK = ~REF_CLK;
   always @(posedge REF_CLK) begin
      {PIX_RED, PIX_GREEN, PIX_BLUE} <= 24'($random(seed));
      {PIX_VSYNC, PIX_HSYNC, PIX_DE, TEAR_OR_IRQ_SRC} <= 4'($random(seed));
      if (MEM_WRITE === 1'b1) begin
         wd <= MEM_WDATA;
         wb <= MEM_WBYTES;
         wn <= wn + 1;
      end
      if (MEM_READ === 1'b1) rn <= rn + 1;
   end
   function automatic logic [15:0] msk(input logic narrow);
      return narrow ? 16'h00ff : 16'hffff;
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      i_hpm_host.cyc(1'b0, 1'b0, {8'h00, a});
      i_hpm_host.cyc(1'b0, 1'b1, v);
      repeat (3) @(posedge REF_CLK);
      @(negedge REF_CLK);
   endtask
   // Index write then one read; the model keeps what the lines showed
   task automatic rd(input logic [7:0] a);
      i_hpm_host.cyc(1'b0, 1'b0, {8'h00, a});
      i_hpm_host.cyc(1'b1, 1'b1, 16'h0000);
   endtask
   task automatic finish_test;
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #100000;
      error_cnt++;
      finish_test;
   end
   initial begin
      for (int m = 0; m < 8; m++) begin
         @(posedge REF_CLK);
         RST <= 1'b1;
         // Straps only ever move while reset is held
         CONFIG_STRAPS <= m[2:0];
         MEM_RDATA <= 16'($random(seed));
         repeat (12) @(posedge REF_CLK);
         RST <= 1'b0;
         @(negedge REF_CLK);
         chk(16'({BUS_IS_8BIT, BUS_IS_ALE, STRAP_RESERVED}),
            16'({m[0], m[2:1] == 2'h1, m[2]}));
         d = 16'($random(seed));
         n = wn + rn;
         if (m[1]) i_hpm_host.ale(HPM_MEM_PORT_LOW_OFFSET);
         else i_hpm_host.cyc(1'b0, 1'b0, {8'h00, HPM_MEM_PORT_LOW_OFFSET});
         // Latch pulse in strobe mode must not move the index
         if (!m[1]) i_hpm_host.ale(HPM_COLOUR_CTRL_OFFSET);
         i_hpm_host.cyc(1'b0, 1'b1, d);
         i_hpm_host.cyc(1'b1, 1'b1, d);
         repeat (3) @(posedge REF_CLK);
         @(negedge REF_CLK);
         chk(16'(wn + rn - n), m[2] ? 16'h0 : 16'h2);
         if (!m[2]) begin
            chk(wd & msk(m[0]), d & msk(m[0]));
            chk(16'(wb), m[0] ? 16'h1 : 16'h3);
            chk(i_hpm_host.q & msk(m[0]), MEM_RDATA & msk(m[0]));
            wr(HPM_MEM_PORT_HIGH_OFFSET, d);
            chk({wd[15:8], 6'h00, wb}, {d[7:0], 8'h02});
            wr(HPM_GPO_LOW_OFFSET, d);
            chk(16'({PANEL_RED_LINE[1:0], PANEL_GREEN_LINE[1:0],
               GENERAL_OUTPUT}), 16'({d[5:4], d[7:6], d[3:0]}));
            wr(HPM_GPO_HIGH_OFFSET, d);
            chk(16'(PANEL_BLUE_LINE[1:0]), 16'(d[1:0]));
            rd(HPM_STRAP_STATUS_OFFSET);
            chk(i_hpm_host.q, 16'({m[2:1] == 2'h1, m[0]}));
            wr(HPM_COLOUR_CTRL_OFFSET, 16'h0001);
            chk(16'(COLOUR_24BPP), 16'h0001);
            rd(HPM_COLOUR_CTRL_OFFSET);
            chk(i_hpm_host.q, 16'h0001);
         end
         $display("mode %0d done", m);
      end
      finish_test;
   end
endmodule
`default_nettype wire

//--- logic/hpm_colour_lane.sv
`default_nettype none
module hpm_colour_lane #(
   parameter int LANE_BITS = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [LANE_BITS-1:0] pixel,
   input wire logic deep,
   input wire logic [1:0] general_output,
   output logic [LANE_BITS-1:0] line
);
   typedef struct packed {
      logic [LANE_BITS-1:0] line;
   } hpm_lane_t;
   hpm_lane_t s;
   hpm_lane_t next_s;

   // Two low lines are lent out, so a lane needs pixel bits left over
   if (LANE_BITS < 3) begin
      $error("LANE_BITS must be at least 3");
   end

   always_comb begin
      next_s.line = pixel;
      // Shallow depth hands the two lowest lines to general outputs
      if (!deep) begin
         next_s.line[1:0] = general_output;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign line = s.line;
endmodule
`default_nettype wire

//--- logic/hpm_pin_mux.sv
// What this block does
// - Width strap high 8-bit bus, low 16-bit
// - Type strap 00 strobe, 01 latch, 1x reserved
// - 8-bit mode: every register access single byte
// - 16-bit mode: memory port 66h is 16-bit, 67h stays one byte
// - 8-bit mode ignores and never drives upper lines
// - Latch enable only used in latch mode
// - Register 14h bit 0 picks 24 or 18 bpp
`default_nettype none
module hpm_pin_mux (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic [2:0] CONFIG_STRAPS,
   input wire logic HOST_CHIP_SEL_N,
   input wire logic HOST_READ_STROBE_N,
   input wire logic HOST_WRITE_STROBE_N,
   input wire logic HOST_DATA_CMD_SEL,
   input wire logic HOST_ADDR_LATCH_EN,
   input wire logic [15:0] HOST_DATA_LINES_IN,
   output logic [15:0] HOST_DATA_LINES_OUT,
   output logic HOST_DATA_OE_LOW,
   output logic HOST_DATA_OE_HIGH,
   input wire logic TEAR_OR_IRQ_SRC,
   output logic TEAR_OR_IRQ_OUT,
   input wire logic [15:0] MEM_RDATA,
   output logic [15:0] MEM_WDATA,
   output logic [1:0] MEM_WBYTES,
   output logic MEM_WRITE,
   output logic MEM_READ,
   input wire logic [hpm_pkg::HPM_LANE_BITS-1:0] PIX_RED,
   input wire logic [hpm_pkg::HPM_LANE_BITS-1:0] PIX_GREEN,
   input wire logic [hpm_pkg::HPM_LANE_BITS-1:0] PIX_BLUE,
   input wire logic PIX_VSYNC,
   input wire logic PIX_HSYNC,
   input wire logic PIX_DE,
   output logic [hpm_pkg::HPM_LANE_BITS-1:0] PANEL_RED_LINE,
   output logic [hpm_pkg::HPM_LANE_BITS-1:0] PANEL_GREEN_LINE,
   output logic [hpm_pkg::HPM_LANE_BITS-1:0] PANEL_BLUE_LINE,
   output logic PANEL_VSYNC,
   output logic PANEL_HSYNC,
   output logic PANEL_DATA_ENABLE,
   output logic [3:0] GENERAL_OUTPUT,
   output logic BUS_IS_8BIT,
   output logic BUS_IS_ALE,
   output logic STRAP_RESERVED,
   output logic COLOUR_24BPP
);
   import hpm_pkg::*;

   typedef struct packed {
      logic bus8;
      logic ale_mode;
      logic rsvd;
      logic [7:0] addr;
      logic wr_q;
      logic rd_q;
      logic [15:0] wdat;
      logic deep;
      logic [HPM_GPO_BITS-1:0] general_output;
      logic [15:0] dout;
      logic oe_lo;
      logic oe_hi;
      logic [15:0] mwdata;
      logic [1:0] mwbytes;
      logic mwrite;
      logic mread;
      logic tear;
      logic vs;
      logic hs;
      logic de;
   } hpm_state_t;

   hpm_state_t s;
   hpm_state_t next_s;
   logic wr_act;
   logic rd_act;
   logic wr_end;
   logic rd_end;
   logic [15:0] rdata;

   always_comb begin
      next_s = s;
      next_s.mwrite = 1'b0;
      next_s.mread = 1'b0;
      next_s.tear = TEAR_OR_IRQ_SRC;
      next_s.vs = PIX_VSYNC;
      next_s.hs = PIX_HSYNC;
      next_s.de = PIX_DE;
      // A reserved bus type leaves the host port dead rather than guessing
      wr_act = !HOST_CHIP_SEL_N && !HOST_WRITE_STROBE_N && !s.rsvd;
      rd_act = !HOST_CHIP_SEL_N && !HOST_READ_STROBE_N && !s.rsvd;
      wr_end = s.wr_q && !wr_act;
      rd_end = s.rd_q && !rd_act;
      next_s.wr_q = wr_act;
      next_s.rd_q = rd_act;
      // Data is kept from the last strobe cycle so hold time is honoured
      if (wr_act) begin
         next_s.wdat = HOST_DATA_LINES_IN;
         if (s.bus8) begin
            next_s.wdat[15:8] = 8'h00;
         end
      end

      rdata = 16'h0000;
      case (s.addr)
         HPM_COLOUR_CTRL_OFFSET: begin
            rdata[HPM_DEPTH_BIT] = s.deep;
         end
         HPM_GPO_LOW_OFFSET: begin
            rdata[7:0] = s.general_output[7:0];
         end
         HPM_GPO_HIGH_OFFSET: begin
            rdata[HPM_GPO_BITS-9:0] = s.general_output[HPM_GPO_BITS-1:8];
         end
         HPM_STRAP_STATUS_OFFSET: begin
            rdata[HPM_STATUS_WIDTH_BIT] = s.bus8;
            rdata[HPM_STATUS_ALE_BIT] = s.ale_mode;
            rdata[HPM_STATUS_RSVD_BIT] = s.rsvd;
         end
         HPM_MEM_PORT_LOW_OFFSET: begin
            if (s.bus8) begin
               rdata[7:0] = MEM_RDATA[7:0];
            end else begin
               rdata = MEM_RDATA;
            end
         end
         HPM_MEM_PORT_HIGH_OFFSET: begin
            rdata[7:0] = MEM_RDATA[15:8];
         end
         default: begin
            rdata = 16'h0000;
         end
      endcase

      next_s.oe_lo = rd_act;
      // Only the wide memory port ever drives the upper lines
      next_s.oe_hi = rd_act && !s.bus8
         && (s.addr == HPM_MEM_PORT_LOW_OFFSET);
      next_s.dout = rd_act ? rdata : 16'h0000;
      if (rd_end && (s.addr == HPM_MEM_PORT_LOW_OFFSET
            || s.addr == HPM_MEM_PORT_HIGH_OFFSET)) begin
         next_s.mread = 1'b1;
      end

      // Latch mode takes the index while the latch enable is high
      if (s.ale_mode && HOST_ADDR_LATCH_EN && !HOST_CHIP_SEL_N
            && !s.rsvd) begin
         next_s.addr = HOST_DATA_LINES_IN[7:0];
      end

      if (wr_end) begin
         if (!HOST_DATA_CMD_SEL) begin
            next_s.addr = s.wdat[7:0];
         end else begin
            case (s.addr)
               HPM_COLOUR_CTRL_OFFSET: begin
                  next_s.deep = s.wdat[HPM_DEPTH_BIT];
               end
               HPM_GPO_LOW_OFFSET: begin
                  next_s.general_output[7:0] = s.wdat[7:0];
               end
               HPM_GPO_HIGH_OFFSET: begin
                  next_s.general_output[HPM_GPO_BITS-1:8] = s.wdat[HPM_GPO_BITS-9:0];
               end
               HPM_MEM_PORT_LOW_OFFSET: begin
                  next_s.mwrite = 1'b1;
                  if (s.bus8) begin
                     next_s.mwdata = {8'h00, s.wdat[7:0]};
                     next_s.mwbytes = 2'h1;
                  end else begin
                     next_s.mwdata = s.wdat;
                     next_s.mwbytes = 2'h3;
                  end
               end
               HPM_MEM_PORT_HIGH_OFFSET: begin
                  next_s.mwrite = 1'b1;
                  next_s.mwdata = {s.wdat[7:0], 8'h00};
                  next_s.mwbytes = 2'h2;
               end
               default: begin
                  next_s.mwrite = 1'b0;
               end
            endcase
         end
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         s <= '0;
         s.deep <= HPM_DEPTH_RESET;
         s.general_output <= HPM_GPO_RESET;
         // Straps are only looked at here; later wiggles change nothing
         s.bus8 <= CONFIG_STRAPS[HPM_STRAP_WIDTH_BIT];
         s.ale_mode <= CONFIG_STRAPS[HPM_STRAP_TYPE_MSB:HPM_STRAP_TYPE_LSB]
            == HPM_TYPE_ALE;
         s.rsvd <= CONFIG_STRAPS[HPM_STRAP_TYPE_MSB];
      end else begin
         s <= next_s;
      end
   end

   hpm_colour_lane #(.LANE_BITS(HPM_LANE_BITS)) u_red (
      .clk(REF_CLK),
      .rst(RST),
      .pixel(PIX_RED),
      .deep(s.deep),
      .general_output(s.general_output[5:4]),
      .line(PANEL_RED_LINE)
   );
   hpm_colour_lane #(.LANE_BITS(HPM_LANE_BITS)) u_green (
      .clk(REF_CLK),
      .rst(RST),
      .pixel(PIX_GREEN),
      .deep(s.deep),
      .general_output(s.general_output[7:6]),
      .line(PANEL_GREEN_LINE)
   );
   hpm_colour_lane #(.LANE_BITS(HPM_LANE_BITS)) u_blue (
      .clk(REF_CLK),
      .rst(RST),
      .pixel(PIX_BLUE),
      .deep(s.deep),
      .general_output(s.general_output[9:8]),
      .line(PANEL_BLUE_LINE)
   );

   assign HOST_DATA_LINES_OUT = s.dout;
   assign HOST_DATA_OE_LOW = s.oe_lo;
   assign HOST_DATA_OE_HIGH = s.oe_hi;
   assign TEAR_OR_IRQ_OUT = s.tear;
   assign MEM_WDATA = s.mwdata;
   assign MEM_WBYTES = s.mwbytes;
   assign MEM_WRITE = s.mwrite;
   assign MEM_READ = s.mread;
   assign PANEL_VSYNC = s.vs;
   assign PANEL_HSYNC = s.hs;
   assign PANEL_DATA_ENABLE = s.de;
   assign GENERAL_OUTPUT = s.general_output[3:0];
   assign BUS_IS_8BIT = s.bus8;
   assign BUS_IS_ALE = s.ale_mode;
   assign STRAP_RESERVED = s.rsvd;
   assign COLOUR_24BPP = s.deep;
endmodule
`default_nettype wire

//--- logic/hpm_pkg.sv
`default_nettype none
package hpm_pkg;
   localparam logic [7:0] HPM_COLOUR_CTRL_OFFSET = 8'h14;
   localparam logic [7:0] HPM_GPO_LOW_OFFSET = 8'h16;
   localparam logic [7:0] HPM_GPO_HIGH_OFFSET = 8'h17;
   localparam logic [7:0] HPM_STRAP_STATUS_OFFSET = 8'h18;
   localparam logic [7:0] HPM_MEM_PORT_LOW_OFFSET = 8'h66;
   localparam logic [7:0] HPM_MEM_PORT_HIGH_OFFSET = 8'h67;
   localparam int HPM_DEPTH_BIT = 0;
   localparam int HPM_STRAP_WIDTH_BIT = 0;
   localparam int HPM_STRAP_TYPE_LSB = 1;
   localparam int HPM_STRAP_TYPE_MSB = 2;
   localparam int HPM_STATUS_WIDTH_BIT = 0;
   localparam int HPM_STATUS_ALE_BIT = 1;
   localparam int HPM_STATUS_RSVD_BIT = 2;
   localparam logic [1:0] HPM_TYPE_STROBE = 2'h0;
   localparam logic [1:0] HPM_TYPE_ALE = 2'h1;
   localparam logic HPM_DEPTH_RESET = 1'h0;
   localparam logic [9:0] HPM_GPO_RESET = 10'h000;
   localparam int HPM_LANE_BITS = 8;
   localparam int HPM_GPO_BITS = 10;
endpackage
`default_nettype wire
